// file: bench/bmf_sva.sv
// bmf_sva: concurrent checks on the host/engine link and the memory strobes
// assumes: instantiated beside bmf_if in the bench, everything on ref_clk
`timescale 1ns/1ns
module bmf_sva (
  input wire logic                       ref_clk,         // system clock
  input wire logic                       srst,            // synchronous reset
  input wire logic                       trig_move,       // move/fill trigger level
  input wire logic                       trig_search,     // search trigger level
  input wire logic                       busy,            // sequence running
  input wire logic [2:0]                 count_exhausted, // sticky per channel
  input wire logic                       match,           // search halted on equality
  input wire logic [bmf_pkg::DATA_W-1:0] cmp_byte,        // compare port
  input wire logic                       mem_rd,          // read strobe
  input wire logic                       mem_wr,          // write strobe
  input wire logic                       mem_wdata_oe,    // latch drives data bus
  input wire logic [bmf_pkg::DATA_W-1:0] mem_rdata        // read data
);
  // ************************************************************
  // properties, all in the one clock domain
  // ************************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  // bus contention would corrupt the latched byte
  a_rd_wr_excl: assert property (!(mem_rd && mem_wr))
    else $error("read and write strobes together");
  a_wr_drives: assert property (mem_wr |-> mem_wdata_oe)
    else $error("write without latch driving");
  a_strobe_busy: assert property ((mem_rd || mem_wr) |-> busy)
    else $error("memory cycle while idle");
  a_rd_then_wr: assert property ((mem_rd && trig_move) |=> !mem_rd until mem_wr)
    else $error("two reads without a write between");
  // bound of 1000 covers the default pacing slot as well
  a_wr_follows: assert property ((mem_rd && trig_move) |-> ##[1:1000] mem_wr)
    else $error("read not followed by a write");
  a_search_no_wr: assert property (trig_search |-> !mem_wr && !mem_wdata_oe)
    else $error("write during search");
  a_cmp_load: assert property ((mem_rd && trig_search) |=> cmp_byte == $past(mem_rdata))
    else $error("compare port not loaded");
  a_match_halts: assert property ($rose(match) |-> !mem_rd [*4])
    else $error("read after match");
  a_ch0_stops: assert property ((count_exhausted[0] && $past(count_exhausted[0]) && trig_move) |-> !mem_rd)
    else $error("read after channel 0 exhausted");
  a_end_cause: assert property (($fell(busy) && !$past(srst)) |-> (count_exhausted != 3'h0) || match)
    else $error("sequence ended without cause");
endmodule : bmf_sva

// file: bench/bmf_tb.sv
// bmf_tb: both ends joined by bmf_if, bench plays the byte memory
// assumes: PACE shortened to 4; memory reads answer combinationally
`timescale 1ns/1ns
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin num_errors++; \
  $display("CHECK FAILED t=%0t got %0h exp %0h", $time, g, e); end end
module bmf_tb;
  typedef struct {bmf_pkg::bmf_op_e op; logic [15:0] src, dst; logic [13:0] len_m1;
                  logic [7:0] value; logic found; logic [15:0] hit;} bmf_row_s;
  localparam int PACE = 4;      // short pacing keeps the run brief
  logic        ref_clk, srst, start, done, found, mem_rd, mem_wr, mem_wdata_oe;
  logic [15:0] src, dst, hit_addr, mem_addr;
  logic [13:0] len_m1;
  logic [7:0]  value, mem_wdata;
  bmf_pkg::bmf_op_e op;
  logic [7:0]  mem [0:65535];   // byte memory seen by the engine
  int          num_errors, total_checks, rd_cnt, wr_cnt, cyc, rd_exp;
  bmf_row_s    rows [5];
  bmf_if lnk ();
  bmf_engine #(.PACE(PACE)) bmf_engine_i (.ref_clk(ref_clk), .srst(srst), .lnk(lnk), .mem_rd(mem_rd),
    .mem_wr(mem_wr), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_wdata_oe(mem_wdata_oe),
    .mem_rdata(mem[mem_addr]));
  bmf_host bmf_host_i (.ref_clk(ref_clk), .srst(srst), .lnk(lnk), .start(start), .op(op), .src(src),
    .dst(dst), .len_m1(len_m1), .value(value), .done(done), .found(found), .hit_addr(hit_addr));
  bmf_sva bmf_sva_i (.ref_clk(ref_clk), .srst(srst), .trig_move(lnk.trig_move),
    .trig_search(lnk.trig_search), .busy(lnk.busy), .count_exhausted(lnk.count_exhausted),
    .match(lnk.match), .cmp_byte(lnk.cmp_byte), .mem_rd(mem_rd), .mem_wr(mem_wr),
    .mem_wdata_oe(mem_wdata_oe), .mem_rdata(mem[mem_addr]));
  // ************************************************************
  // clock, memory and strobe counters
  // ************************************************************
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  // pattern unique per low byte, so a search has one answer
  function automatic logic [7:0] pat(input logic [15:0] a);
    return a[7:0] ^ 8'h5A;
  endfunction : pat
  always @(posedge ref_clk) begin
    if (mem_wr) mem[mem_addr] <= mem_wdata;
    if (mem_rd) rd_cnt++;
    if (mem_wr) wr_cnt++;
  end
  task automatic tick();
    @(posedge ref_clk);
    #1;
  endtask : tick
  task automatic close_out();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : close_out
  // one start pulse, then a bounded wait for done
  task automatic run(input bmf_row_s r);
    rd_cnt = 0;
    wr_cnt = 0;
    {op, src, dst, len_m1, value} = {r.op, r.src, r.dst, r.len_m1, r.value};
    start = 1'b1;
    tick();
    start = 1'b0;
    for (cyc = 0; cyc < 3000 && done !== 1'b1; cyc++) tick();
    if (done !== 1'b1) begin
      num_errors++;
      $display("CHECK FAILED t=%0t no completion", $time);
      close_out();
    end
  endtask : run
  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    {srst, start, src, dst, len_m1, value, num_errors, total_checks} = '0;
    op = bmf_pkg::BMF_OP_MOVE;
    for (int i = 0; i < 65536; i++) mem[i] = pat(16'(i));
    rows[0] = '{bmf_pkg::BMF_OP_MOVE, 16'h0010, 16'h0100, 14'h0003, 8'h00, 1'b0, 16'h0000};
    rows[1] = '{bmf_pkg::BMF_OP_FILL, 16'h0020, 16'h0200, 14'h0004, 8'h00, 1'b0, 16'h0000};
    rows[2] = '{bmf_pkg::BMF_OP_SEARCH, 16'h0030, 16'h0000, 14'h0007, pat(16'h0035), 1'b1, 16'h0035};
    rows[3] = '{bmf_pkg::BMF_OP_SEARCH, 16'h0030, 16'h0000, 14'h0003, pat(16'h0050), 1'b0, 16'h0000};
    rows[4] = '{bmf_pkg::BMF_OP_MOVE, 16'h0040, 16'h0300, 14'h0000, 8'h00, 1'b0, 16'h0000};
    srst = 1'b1;
    repeat (6) tick();
    srst = 1'b0;
    `CHK({done, lnk.busy, mem_rd, mem_wr}, 4'h0)
    foreach (rows[n]) begin
      run(rows[n]);
      if (rows[n].op == bmf_pkg::BMF_OP_SEARCH) begin
        rd_exp = rows[n].found ? int'(rows[n].hit - rows[n].src) + 1 : int'(rows[n].len_m1) + 1;
        `CHK(found, rows[n].found)
        `CHK(rd_cnt, rd_exp)
        if (rows[n].found) `CHK(hit_addr, rows[n].hit)
        if (rows[n].found) `CHK(lnk.cmp_byte, rows[n].value)
      end else begin
        rd_exp = (rows[n].op == bmf_pkg::BMF_OP_FILL) ? 1 : int'(rows[n].len_m1) + 1;
        `CHK(rd_cnt, rd_exp)
        `CHK(wr_cnt, int'(rows[n].len_m1) + 1)
        for (int i = 0; i <= rows[n].len_m1; i++)
          `CHK(mem[rows[n].dst + 16'(i)], pat(rows[n].op == bmf_pkg::BMF_OP_FILL ? rows[n].src
                                               : rows[n].src + 16'(i)))
        // the byte just past the block must stay untouched
        `CHK(mem[rows[n].dst + 16'(rows[n].len_m1) + 16'h0001],
             pat(rows[n].dst + 16'(rows[n].len_m1) + 16'h0001))
      end
      // pacing: one word costs PACE cycles plus a short idle per slot
      if (n == 0) `CHK(cyc >= 4 * PACE && cyc <= 4 * (PACE + 2) + 10, 1'b1)
    end
    // reset in mid-search: everything idle afterwards, then a move still works
    {op, src, len_m1, value, start} = {bmf_pkg::BMF_OP_SEARCH, 16'h0000, 14'h0080, 8'hFF, 1'b1};
    tick();
    start = 1'b0;
    repeat (20) tick();
    srst = 1'b1;
    tick();
    srst = 1'b0;
    repeat (8) tick();
    `CHK({lnk.busy, lnk.match, lnk.count_exhausted, mem_rd}, 6'h00)
    run(rows[0]);
    `CHK(wr_cnt, 4)
    close_out();
  end
endmodule : bmf_tb

// file: hdl/bmf_engine.sv
// bmf_engine: three-channel transfer engine with data latch and search comparator
// assumes: host end drives bmf_if.host; memory answers reads combinationally in the same cycle
`timescale 1ns/1ns
module bmf_engine #(
  parameter int PACE = bmf_pkg::WORD_CYC // cycles per moved word
) (
  input  wire logic                       ref_clk,   // system clock
  input  wire logic                       srst,      // synchronous reset
  bmf_if.dev                              lnk,       // host side
  output logic                            mem_rd,    // memory read strobe
  output logic                            mem_wr,    // memory write strobe
  output logic [bmf_pkg::ADDR_W-1:0]      mem_addr,  // memory address
  output logic [bmf_pkg::DATA_W-1:0]      mem_wdata, // write data from latch
  output logic                            mem_wdata_oe, // latch drives data bus
  input  wire logic [bmf_pkg::DATA_W-1:0] mem_rdata  // read data
);

  // ************************************************************
  // channel registers
  // ************************************************************
  logic [bmf_pkg::ADDR_W-1:0] addr_r [3];   // current address per channel
  logic [bmf_pkg::CNT_W-1:0]  cnt_r  [3];   // remaining count per channel
  logic [2:0]                 en_r;         // channel enabled
  logic [2:0]                 req_r;        // request latched from trigger
  logic [2:0]                 tc_r;         // sticky count_exhausted
  logic [bmf_pkg::DATA_W-1:0] latch_r;      // intermediate data latch
  logic [bmf_pkg::DATA_W-1:0] cmp_r;        // compare port
  logic                       match_r;      // equality seen
  logic                       cmp_ok_r;     // compare port holds a byte of the current search
  logic                       last_r;       // last serviced of channel 0/1 (rotation)
  logic [bmf_pkg::CYC_W-1:0]  pace_r;       // slot pacing counter
  bmf_pkg::bmf_st_e           st_r;         // current slot owner
  bmf_pkg::bmf_st_e           st_nxt;

  // slot length: half the word time for moves, rounded down, never below one
  localparam logic [bmf_pkg::CYC_W-1:0] SLOT =
    (PACE / 2 < 1) ? bmf_pkg::CYC_W'(1) : bmf_pkg::CYC_W'(PACE / 2);

  // ************************************************************
  // decode
  // ************************************************************
  wire       slot_end = (pace_r == SLOT - bmf_pkg::CYC_W'(1)); // memory cycle happens here
  wire       act0     = en_r[0] & req_r[0];                   // channel 0 pending
  wire       act1     = en_r[1] & req_r[1];                   // channel 1 pending
  wire       equal    = (cmp_r == lnk.ref_byte);              // 8-bit comparator
  // a stale compare byte from an earlier search must not halt a new one
  wire       hit      = equal & cmp_ok_r;                     // qualified equality
  wire       act2     = en_r[2] & req_r[2] & ~match_r & ~hit; // gated request
  wire [1:0] cur      = (st_r == bmf_pkg::BMF_ST_CH1) ? 2'd1 :
                        (st_r == bmf_pkg::BMF_ST_CH2) ? 2'd2 : 2'd0;
  wire       cur_tc   = (cnt_r[cur] == bmf_pkg::CNT_RST);      // this cycle is the last
  wire       do_cyc   = (st_r != bmf_pkg::BMF_ST_IDLE) & slot_end;

  // ************************************************************
  // rotating arbiter: after channel 0, channel 1 wins if pending
  // ************************************************************
  always_comb begin
    if (act0 && act1) begin
      st_nxt = last_r ? bmf_pkg::BMF_ST_CH0 : bmf_pkg::BMF_ST_CH1;
    end else if (act0) begin
      st_nxt = bmf_pkg::BMF_ST_CH0;
    end else if (act1) begin
      st_nxt = bmf_pkg::BMF_ST_CH1; // fill keeps writing once channel 0 is gone
    end else if (act2) begin
      st_nxt = bmf_pkg::BMF_ST_CH2;
    end else begin
      st_nxt = bmf_pkg::BMF_ST_IDLE;
    end
  end

  // ************************************************************
  // memory strobes; channel 2 acknowledge steers the read to the compare port
  // ************************************************************
  assign mem_rd       = do_cyc & (st_r != bmf_pkg::BMF_ST_CH1);
  assign mem_wr       = do_cyc & (st_r == bmf_pkg::BMF_ST_CH1);
  assign mem_wdata_oe = (st_r == bmf_pkg::BMF_ST_CH1);
  assign mem_addr     = addr_r[cur];
  assign mem_wdata    = latch_r;

  // ************************************************************
  // slot sequencer and pacing
  // ************************************************************
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      st_r   <= bmf_pkg::BMF_ST_IDLE;
      pace_r <= '0;
      last_r <= 1'b1;
    end else if (st_r == bmf_pkg::BMF_ST_IDLE || do_cyc) begin
      // pick next owner; pacing keeps a word near 2.5 us
      st_r   <= (do_cyc && st_r != bmf_pkg::BMF_ST_IDLE) ? bmf_pkg::BMF_ST_IDLE : st_nxt;
      pace_r <= '0;
      if (do_cyc && st_r != bmf_pkg::BMF_ST_CH2) begin
        last_r <= (st_r == bmf_pkg::BMF_ST_CH1);
      end
    end else begin
      pace_r <= pace_r + bmf_pkg::CYC_W'(1);
    end
  end

  // ************************************************************
  // per-channel address, count, enable and request
  // ************************************************************
  for (genvar c = 0; c < 3; c++) begin : g_ch
    wire mine = do_cyc & (cur == 2'(c));
    wire trig = (c == 2) ? lnk.trig_search : lnk.trig_move;
    always_ff @(posedge ref_clk) begin
      if (srst) begin
        addr_r[c] <= bmf_pkg::ADDR_RST;
        cnt_r[c]  <= bmf_pkg::CNT_RST;
        en_r[c]   <= 1'b0;
        req_r[c]  <= 1'b0;
        tc_r[c]   <= 1'b0;
      end else if (lnk.prog_we && lnk.prog_ch == 2'(c)) begin
        addr_r[c] <= lnk.prog_addr;
        cnt_r[c]  <= lnk.prog_cnt;
        en_r[c]   <= 1'b1;
        tc_r[c]   <= 1'b0;
      end else begin
        req_r[c] <= trig;
        if (mine) begin
          // fill source advances too, like the others, even when exhausted
          addr_r[c] <= addr_r[c] + bmf_pkg::ADDR_W'(1); // leaves ch2 one past match
          if (cur_tc) begin
            tc_r[c] <= 1'b1;
            if (lnk.auto_stop) begin
              en_r[c] <= 1'b0;
            end
          end else begin
            cnt_r[c] <= cnt_r[c] - bmf_pkg::CNT_W'(1);
          end
        end
      end
    end
  end

  // ************************************************************
  // data latch and compare port
  // ************************************************************
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      latch_r <= bmf_pkg::BYTE_RST;
      cmp_r   <= bmf_pkg::BYTE_RST;
      match_r <= 1'b0;
      cmp_ok_r <= 1'b0;
    end else begin
      if (do_cyc && st_r == bmf_pkg::BMF_ST_CH0) begin
        latch_r <= mem_rdata; // capture only on channel 0 read
      end
      if (do_cyc && st_r == bmf_pkg::BMF_ST_CH2) begin
        cmp_r <= mem_rdata;
      end
      if (lnk.prog_we && lnk.prog_ch == 2'd2) begin
        match_r  <= 1'b0; // new search clears old hit
        cmp_ok_r <= 1'b0;
      end else if (do_cyc && st_r == bmf_pkg::BMF_ST_CH2) begin
        cmp_ok_r <= 1'b1; // first byte of this search is in
      end else if (en_r[2] && req_r[2] && hit && st_r == bmf_pkg::BMF_ST_IDLE) begin
        match_r <= 1'b1;
      end
    end
  end

  // ************************************************************
  // status
  // ************************************************************
  // stay busy through the cycle in which a match is being recorded, so the host sees it
  assign lnk.busy            = (st_r != bmf_pkg::BMF_ST_IDLE) | act0 | act1 | act2 |
                               (en_r[2] & req_r[2] & hit & ~match_r);
  assign lnk.count_exhausted = tc_r;
  assign lnk.match           = match_r;
  assign lnk.ch2_addr        = addr_r[2];
  assign lnk.cmp_byte        = cmp_r;

endmodule : bmf_engine

// file: hdl/bmf_host.sv
// bmf_host: host end that programs channels and starts a move, fill or search
// assumes: user pulses start with op, src, dst, len and value; engine on bmf_if.dev
`timescale 1ns/1ns
module bmf_host (
  input  wire logic                       ref_clk,  // system clock
  input  wire logic                       srst,     // synchronous reset
  bmf_if.host                             lnk,      // engine side
  input  wire logic                       start,    // one-cycle start pulse
  input  wire bmf_pkg::bmf_op_e           op,       // move, fill or search
  input  wire logic [bmf_pkg::ADDR_W-1:0] src,      // source / fill / search start
  input  wire logic [bmf_pkg::ADDR_W-1:0] dst,      // destination start
  input  wire logic [bmf_pkg::CNT_W-1:0]  len_m1,   // length minus one
  input  wire logic [bmf_pkg::DATA_W-1:0] value,    // search value
  output logic                            done,     // one-cycle completion pulse
  output logic                            found,    // search found a match before the last byte of the area
  output logic [bmf_pkg::ADDR_W-1:0]      hit_addr  // matching location
);

  // ************************************************************
  // sequence: program ch a, program ch b (skipped for search), trigger, wait
  // ************************************************************
  logic [2:0]                 step_r;  // 0 idle,1 prog0,2 prog1,3 trig,4 wait
  bmf_pkg::bmf_op_e           op_r;
  logic [bmf_pkg::DATA_W-1:0] ref_r;
  logic                       done_r, found_r;
  logic [bmf_pkg::ADDR_W-1:0] hit_r;
  wire  srch = (op_r == bmf_pkg::BMF_OP_SEARCH);

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      step_r <= 3'd0; op_r <= bmf_pkg::BMF_OP_MOVE; ref_r <= bmf_pkg::BYTE_RST;
      done_r <= 1'b0; found_r <= 1'b0; hit_r <= bmf_pkg::ADDR_RST;
    end else begin
      done_r <= 1'b0;
      if (step_r == 3'd0 && start) begin
        step_r <= 3'd1; op_r <= op; ref_r <= value;
      end else if (step_r == 3'd1 || step_r == 3'd2) begin
        step_r <= (srch && step_r == 3'd1) ? 3'd3 : step_r + 3'd1;
      end else if (step_r == 3'd3) begin
        step_r <= 3'd4;
      end else if (step_r == 3'd4 && !lnk.busy) begin
        step_r  <= 3'd0;
        done_r  <= 1'b1;
        found_r <= srch & lnk.match & ~lnk.count_exhausted[2];
        hit_r   <= lnk.ch2_addr - bmf_pkg::ADDR_W'(1);
      end
    end
  end

  // ************************************************************
  // programming port: ch0 source ch1 dest ch2 area
  // ************************************************************
  assign lnk.prog_we   = (step_r == 3'd1) | (step_r == 3'd2);
  assign lnk.prog_ch   = srch ? 2'd2 : (step_r == 3'd1 ? 2'd0 : 2'd1);
  assign lnk.prog_addr = (step_r == 3'd2) ? dst : src;
  assign lnk.prog_cnt  = (step_r == 3'd1 && op_r == bmf_pkg::BMF_OP_FILL) ? bmf_pkg::CNT_RST : len_m1;
  assign lnk.auto_stop = 1'b1;
  assign lnk.ref_byte  = ref_r;
  assign lnk.trig_move   = (step_r >= 3'd3) & ~srch;
  assign lnk.trig_search = (step_r >= 3'd3) & srch;
  assign done     = done_r;
  assign found    = found_r;
  assign hit_addr = hit_r;

endmodule : bmf_host

// file: hdl/bmf_if.sv
// bmf_if: link between the host end and the transfer engine
// assumes: both ends on ref_clk; the bench supplies the memory on mem_* signals
`timescale 1ns/1ns
interface bmf_if;
  // ************************************************************
  // programming and trigger
  // ************************************************************
  logic                          prog_we;      // one-cycle channel programming strobe
  logic [1:0]                    prog_ch;      // channel being programmed
  logic [bmf_pkg::ADDR_W-1:0]    prog_addr;    // start address
  logic [bmf_pkg::CNT_W-1:0]     prog_cnt;     // length minus one
  logic                          auto_stop;    // channels disable at count_exhausted
  logic [bmf_pkg::DATA_W-1:0]    ref_byte;     // search reference port
  logic                          trig_move;    // trigger bit for channels 0 and 1
  logic                          trig_search;  // trigger bit for channel 2
  // ************************************************************
  // status back to host
  // ************************************************************
  logic                          busy;         // a sequence is running
  logic [2:0]                    count_exhausted; // sticky per channel
  logic                          match;        // search halted on equality
  logic [bmf_pkg::ADDR_W-1:0]    ch2_addr;     // channel 2 current address
  logic [bmf_pkg::DATA_W-1:0]    cmp_byte;     // compare port contents

  modport dev  (input prog_we, prog_ch, prog_addr, prog_cnt, auto_stop, ref_byte, trig_move, trig_search,
                output busy, count_exhausted, match, ch2_addr, cmp_byte);
  modport host (output prog_we, prog_ch, prog_addr, prog_cnt, auto_stop, ref_byte, trig_move, trig_search,
                input busy, count_exhausted, match, ch2_addr, cmp_byte);
endinterface : bmf_if

// file: hdl/bmf_pkg.sv
// bmf_pkg: shared constants for the block move / fill / search engine and its host end
// assumes: one 125 MHz clock, synchronous active-high reset, byte-wide memory
package bmf_pkg;

  // ************************************************************
  // sizes and timing
  // ************************************************************
  localparam int          ADDR_W          = 16;      // memory address width
  localparam int          DATA_W          = 8;       // byte data path
  localparam int          CNT_W           = 14;      // count field width
  localparam int          CLK_MHZ         = 125;     // ref_clk rate
  localparam int          WORD_TIME_NS    = 2500;    // target time per moved word
  localparam int          WORD_CYC        = (WORD_TIME_NS * CLK_MHZ) / 1000; // longest time, rounded down
  localparam int          CYC_W           = 12;      // width of the pacing counter
  localparam logic [CYC_W-1:0] HALF_WORD_CYC = CYC_W'(WORD_CYC / 2); // one read or one write slot

  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic [ADDR_W-1:0] ADDR_RST = 16'h0000; // address after reset
  localparam logic [CNT_W-1:0]  CNT_RST  = 14'h0000; // count after reset
  localparam logic [DATA_W-1:0] BYTE_RST = 8'h00;    // latch and ports after reset

  // ************************************************************
  // host operations and channel states
  // ************************************************************
  typedef enum logic [1:0] {
    BMF_OP_MOVE   = 2'h0,
    BMF_OP_FILL   = 2'h1,
    BMF_OP_SEARCH = 2'h2
  } bmf_op_e;

  typedef enum logic [3:0] {
    BMF_ST_IDLE  = 4'h1, // no cycle running
    BMF_ST_CH0   = 4'h2, // channel 0 read slot
    BMF_ST_CH1   = 4'h4, // channel 1 write slot
    BMF_ST_CH2   = 4'h8  // channel 2 compare read slot
  } bmf_st_e;

endpackage : bmf_pkg
